// file: hdl/txt_ctrl_pkg.sv
package txt_ctrl_pkg;

  // byte addresses of the control registers on the bus
  localparam logic [7:0] ACQ_DISPLAY_CTRL_ADDR = 8'h00;
  localparam logic [7:0] ACQ_SYNC_CTRL_ADDR = 8'h04;
  localparam logic [7:0] PAGE_REQUEST_SELECT_ADDR = 8'h08;
  localparam logic [7:0] PAGE_REQUEST_DATA_ADDR = 8'h0c;
  localparam logic [7:0] OSD_STYLE_CTRL_ADDR = 8'h10;
  localparam logic [7:0] REQ_STATUS_ADDR = 8'h14;
  localparam int ADDR_BITS = 8;

  localparam logic [7:0] CTRL_RESET = 8'h00;

  // acq_display_ctrl bit positions
  localparam int ROW24_STORE_PLACE_BIT = 7;
  localparam int ROW24_SHOW_SOURCE_BIT = 6;
  localparam int AUTO_BLANK_BIT = 5;
  localparam int HEADER_ROLL_INHIBIT_BIT = 4;
  localparam int STATUS_ROW_ONLY_BIT = 3;
  localparam int BLANK_DISABLE_BIT = 2;
  localparam int PROGRAMME_LABEL_BIT = 1;
  localparam int INVENTORY_BIT = 0;

  // acq_sync_ctrl bit positions
  localparam int EXTENSION_INHIBIT_BIT = 7;
  localparam int RAW_BYTE_BIT = 6;
  localparam int ACQ_WRITE_INHIBIT_BIT = 5;
  localparam int PKT26_INHIBIT_BIT = 4;
  localparam int ANY_LINE_BIT = 3;
  localparam int FIELD_POLARITY_BIT = 2;
  localparam int HSYNC_POL_BIT = 1;
  localparam int VSYNC_POL_BIT = 0;

  // page_request_select fields
  localparam int REQ_PAGE_LSB = 3;
  localparam int REQ_PAGE_W = 4;
  localparam int REQ_COL_LSB = 0;
  localparam int REQ_COL_W = 3;
  localparam int REQ_VALUE_W = 5;

  // osd_style_ctrl bit positions
  localparam int SYMBOL_BANK_BIT = 7;
  localparam int QUAD_WIDTH_BIT = 6;
  localparam int EAST_WEST_BIT = 5;
  localparam int TALL_SUPPRESS_BIT = 4;
  localparam int BLACK_MESH_BIT = 3;
  localparam int COLOUR_MESH_BIT = 2;
  localparam int SEE_THROUGH_BIT = 1;
  localparam int SHADOW_BIT = 0;

  typedef struct packed {
    logic row24_store_place;
    logic row24_show_source;
    logic header_roll_inhibit;
    logic status_row_only;
    logic programme_label_capture_en;
    logic inventory_capture_en;
    logic extension_decode_inhibit;
    logic raw_byte_mode;
    logic acquisition_write_inhibit;
    logic pkt26_process_inhibit;
    logic any_line_decode;
  } acq_cfg_t;

  typedef struct packed {
    logic symbol_bank_switch_en;
    logic quad_width_en;
    logic eastern_set;
    logic tall_code_suppress;
    logic black_mesh_en;
    logic colour_mesh_en;
    logic black_see_through_en;
    logic shadow_en;
  } osd_cfg_t;

  // one write into the page request memory
  typedef struct packed {
    logic valid;
    logic [REQ_PAGE_W-1:0] page;
    logic [REQ_COL_W-1:0] column;
    logic [REQ_VALUE_W-1:0] value;
  } req_write_t;

endpackage : txt_ctrl_pkg

// file: hdl/page_request_mem.sv
`timescale 1ns/100ps
module page_request_mem
  import txt_ctrl_pkg::*;
#(
  parameter int PAGES = 16,
  parameter int COLUMNS = 8
) (
  input wire logic hclk, // bus clock
  input wire logic hresetn, // async reset, low
  input wire req_write_t wr, // write from register bank
  input wire logic [REQ_PAGE_W-1:0] rd_page, // read page
  input wire logic [REQ_COL_W-1:0] rd_column, // read column
  output logic [REQ_VALUE_W-1:0] rd_value // registered read data
);

  // refuse sizes the page and column fields cannot address
  if (PAGES > (1 << REQ_PAGE_W) || COLUMNS > (1 << REQ_COL_W)) begin : g_bad
    $error("page_request_mem: size exceeds field widths");
  end

  logic [REQ_VALUE_W-1:0] mem_reg [PAGES*COLUMNS];

  function automatic int slot(input logic [REQ_PAGE_W-1:0] p,
                              input logic [REQ_COL_W-1:0] c);
    return int'(p) * COLUMNS + int'(c);
  endfunction : slot

  always_ff @(posedge hclk) begin
    if (wr.valid && int'(wr.page) < PAGES && int'(wr.column) < COLUMNS) begin
      mem_reg[slot(wr.page, wr.column)] <= wr.value;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_value <= '0;
    end else if (int'(rd_page) < PAGES && int'(rd_column) < COLUMNS) begin
      rd_value <= mem_reg[slot(rd_page, rd_column)];
    end else begin
      rd_value <= '0;
    end
  end

endmodule : page_request_mem

// file: hdl/teletext_control_regs.sv
`timescale 1ns/100ps
// Function
// - row24_store_place picks packet 24 memory
// - row24_show_source picks row 24 display memory
// - auto blanking drops overlay during video
// - header_roll_inhibit stops header and time writes
// - status-only shows row 24 alone
// - blanking disable holds overlay output low
// - label capture only while enable set
// - inventory enable captures into block 8
// - extension_decode_inhibit stops extension packet decode
// - raw-byte mode skips error checking
// - acquisition_write_inhibit blocks acquisition memory writes; page request writes still land
// - pkt26_process_inhibit stops packet 26 processing
// - line-range bit widens decode to all lines
// - field polarity picks vsync half-line
// - sync polarity bits invert sync inputs
// - select picks page and column for each data write; the column does not advance
// - bank-switch enable allows symbol banks
// - quad-width enable allows quad characters
// - language bit picks western or eastern
// - suppress tall codes inside osd boxes
// - black and colour mesh enables
// - see-through black and south-east shadow
module teletext_control_regs
  import txt_ctrl_pkg::*;
#(
  parameter int PAGES = 16,
  parameter int COLUMNS = 8,
  parameter int INVENTORY_BLOCK = 8
) (
  input wire logic hclk, // bus clock
  input wire logic hresetn, // async reset, low
  input wire logic hsel, // slave select
  input wire logic [ADDR_BITS-1:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready in
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // slave ready
  output logic hresp, // always okay
  input wire logic hsync_pin, // raw horizontal sync
  input wire logic vsync_pin, // raw vertical sync
  input wire logic vbi_line, // current line is in vbi
  input wire logic video_shown, // picture being displayed
  input wire logic text_blank, // blanking wanted by text
  input wire logic row_is_24, // display row is row 24
  input wire logic [REQ_PAGE_W-1:0] req_rd_page, // acq reads request
  input wire logic [REQ_COL_W-1:0] req_rd_column, // acq reads column
  output logic [REQ_VALUE_W-1:0] req_rd_value, // request data
  output acq_cfg_t acq_cfg, // acquisition controls
  output osd_cfg_t osd_cfg, // display style controls
  output logic pkt24_to_page_mem, // packet 24 stored in page mem
  output logic row24_from_ext_mem, // row 24 shown from ext mem
  output logic row_visible, // text row may be shown
  output logic decode_line_en, // text decode on this line
  output logic [3:0] inventory_block, // block for inventory page
  output logic vsync_late_half, // even-field vsync in 2nd half
  output logic hsync_active, // normalised horizontal sync
  output logic vsync_active, // normalised vertical sync
  output logic overlay_blank // overlay blanking output
);

  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] HTRANS_SEQ = 2'b11;
  localparam logic [2:0] HSIZE_WORD = 3'b010;

  // the block number must fit the four-bit output
  if (INVENTORY_BLOCK > 15) begin : g_bad_inventory
    $error("teletext_control_regs: inventory block out of range");
  end

  logic [7:0] disp_ctrl_reg;
  logic [7:0] sync_ctrl_reg;
  logic [7:0] req_sel_reg;
  logic [7:0] style_ctrl_reg;
  logic wr_pend_reg;
  logic [ADDR_BITS-1:0] wr_addr_reg;
  logic [31:0] rdata_reg;
  logic [2:0] hsync_sync_reg;
  logic [2:0] vsync_sync_reg;
  logic hsync_level_reg;
  logic vsync_level_reg;
  logic overlay_reg;
  logic [REQ_VALUE_W-1:0] last_req_reg;
  req_write_t req_wr;
  logic access;

  function automatic logic word_hit(input logic [ADDR_BITS-1:0] a,
                                    input logic [ADDR_BITS-1:0] r);
    return a == r;
  endfunction : word_hit

  assign access = hsel && hready &&
                  (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // address phase capture; write lands in data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
    end else begin
      wr_pend_reg <= access && hwrite && hsize == HSIZE_WORD;
      wr_addr_reg <= haddr;
    end
  end

  // registers hold until rewritten
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      disp_ctrl_reg <= CTRL_RESET;
    end else if (wr_pend_reg &&
                 word_hit(wr_addr_reg, ACQ_DISPLAY_CTRL_ADDR)) begin
      disp_ctrl_reg <= hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_ctrl_reg <= CTRL_RESET;
    end else if (wr_pend_reg &&
                 word_hit(wr_addr_reg, ACQ_SYNC_CTRL_ADDR)) begin
      sync_ctrl_reg <= hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_sel_reg <= CTRL_RESET;
    end else if (wr_pend_reg &&
                 word_hit(wr_addr_reg, PAGE_REQUEST_SELECT_ADDR)) begin
      req_sel_reg <= hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      style_ctrl_reg <= CTRL_RESET;
    end else if (wr_pend_reg &&
                 word_hit(wr_addr_reg, OSD_STYLE_CTRL_ADDR)) begin
      style_ctrl_reg <= hwdata[7:0];
    end
  end

  // request data goes straight to the selected page and column
  always_comb begin
    req_wr.valid = wr_pend_reg &&
                   word_hit(wr_addr_reg, PAGE_REQUEST_DATA_ADDR);
    req_wr.page = req_sel_reg[REQ_PAGE_LSB +: REQ_PAGE_W];
    req_wr.column = req_sel_reg[REQ_COL_LSB +: REQ_COL_W];
    req_wr.value = hwdata[REQ_VALUE_W-1:0];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_req_reg <= '0;
    end else if (req_wr.valid) begin
      last_req_reg <= req_wr.value;
    end
  end

  page_request_mem #(
    .PAGES(PAGES),
    .COLUMNS(COLUMNS)
  ) u_req_mem (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr(req_wr),
    .rd_page(req_rd_page),
    .rd_column(req_rd_column),
    .rd_value(req_rd_value)
  );

  // write-only control regs read as zero; one status word shows
  // the page request selection and last request written
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_reg <= '0;
    end else if (access && !hwrite) begin
      if (word_hit(haddr, REQ_STATUS_ADDR)) begin
        rdata_reg <= {19'h0, last_req_reg, req_sel_reg};
      end else begin
        rdata_reg <= '0;
      end
    end
  end
  assign hrdata = rdata_reg;

  // acquisition configuration
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acq_cfg <= '0;
    end else begin
      acq_cfg.row24_store_place <= disp_ctrl_reg[ROW24_STORE_PLACE_BIT];
      acq_cfg.row24_show_source <= disp_ctrl_reg[ROW24_SHOW_SOURCE_BIT];
      acq_cfg.header_roll_inhibit <=
        disp_ctrl_reg[HEADER_ROLL_INHIBIT_BIT];
      acq_cfg.status_row_only <= disp_ctrl_reg[STATUS_ROW_ONLY_BIT];
      acq_cfg.programme_label_capture_en <=
        disp_ctrl_reg[PROGRAMME_LABEL_BIT];
      acq_cfg.inventory_capture_en <= disp_ctrl_reg[INVENTORY_BIT];
      acq_cfg.extension_decode_inhibit <=
        sync_ctrl_reg[EXTENSION_INHIBIT_BIT];
      acq_cfg.raw_byte_mode <= sync_ctrl_reg[RAW_BYTE_BIT];
      acq_cfg.acquisition_write_inhibit <=
        sync_ctrl_reg[ACQ_WRITE_INHIBIT_BIT];
      acq_cfg.pkt26_process_inhibit <=
        sync_ctrl_reg[PKT26_INHIBIT_BIT];
      acq_cfg.any_line_decode <= sync_ctrl_reg[ANY_LINE_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osd_cfg <= '0;
    end else begin
      osd_cfg.symbol_bank_switch_en <=
        style_ctrl_reg[SYMBOL_BANK_BIT];
      osd_cfg.quad_width_en <=
        style_ctrl_reg[QUAD_WIDTH_BIT];
      osd_cfg.eastern_set <=
        style_ctrl_reg[EAST_WEST_BIT];
      osd_cfg.tall_code_suppress <=
        style_ctrl_reg[TALL_SUPPRESS_BIT];
      osd_cfg.black_mesh_en <=
        style_ctrl_reg[BLACK_MESH_BIT];
      osd_cfg.colour_mesh_en <=
        style_ctrl_reg[COLOUR_MESH_BIT];
      osd_cfg.black_see_through_en <=
        style_ctrl_reg[SEE_THROUGH_BIT];
      osd_cfg.shadow_en <=
        style_ctrl_reg[SHADOW_BIT];
    end
  end

  // derived datapath controls, one register per concern
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pkt24_to_page_mem <= 1'b0;
    end else begin
      pkt24_to_page_mem <= disp_ctrl_reg[ROW24_STORE_PLACE_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      row24_from_ext_mem <= 1'b0;
    end else begin
      row24_from_ext_mem <= disp_ctrl_reg[ROW24_SHOW_SOURCE_BIT];
    end
  end

  // only row 24 passes while status-only is set
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      row_visible <= 1'b0;
    end else begin
      row_visible <= !disp_ctrl_reg[STATUS_ROW_ONLY_BIT] || row_is_24;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      decode_line_en <= 1'b0;
    end else begin
      decode_line_en <= sync_ctrl_reg[ANY_LINE_BIT] || vbi_line;
    end
  end

  // fixed block; parameter only so a smaller memory can move it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      inventory_block <= '0;
    end else begin
      inventory_block <= 4'(INVENTORY_BLOCK);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vsync_late_half <= 1'b0;
    end else begin
      vsync_late_half <= sync_ctrl_reg[FIELD_POLARITY_BIT];
    end
  end

  // sync pins are asynchronous: three stages, change taken on agreement
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hsync_sync_reg <= '0;
      hsync_level_reg <= 1'b0;
    end else begin
      hsync_sync_reg <= {hsync_sync_reg[1:0], hsync_pin};
      if (hsync_sync_reg[2] == hsync_sync_reg[1]) begin
        hsync_level_reg <= hsync_sync_reg[2];
      end
    end
  end

  // a one-cycle glitch never reaches the level register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vsync_sync_reg <= '0;
      vsync_level_reg <= 1'b0;
    end else begin
      vsync_sync_reg <= {vsync_sync_reg[1:0], vsync_pin};
      if (vsync_sync_reg[2] == vsync_sync_reg[1]) begin
        vsync_level_reg <= vsync_sync_reg[2];
      end
    end
  end

  // polarity bit inverts a negative-going input
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hsync_active <= 1'b0;
    end else begin
      hsync_active <= hsync_level_reg ^ sync_ctrl_reg[HSYNC_POL_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vsync_active <= 1'b0;
    end else begin
      vsync_active <= vsync_level_reg ^ sync_ctrl_reg[VSYNC_POL_BIT];
    end
  end

  // disable beats auto-off, which beats the text request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overlay_reg <= 1'b0;
    end else if (disp_ctrl_reg[BLANK_DISABLE_BIT]) begin
      overlay_reg <= 1'b0;
    end else if (disp_ctrl_reg[AUTO_BLANK_BIT] && video_shown) begin
      overlay_reg <= 1'b0;
    end else begin
      overlay_reg <= text_blank;
    end
  end
  assign overlay_blank = overlay_reg;

endmodule : teletext_control_regs

// file: tb/teletext_control_regs_chk.sv
`timescale 1ns/100ps
module teletext_control_regs_chk
  import txt_ctrl_pkg::*;
#(
  parameter int INVENTORY_BLOCK = 8
) (
  input wire logic hclk, // clock
  input wire logic hresetn, // reset, low
  input wire logic hsel, // select
  input wire logic [ADDR_BITS-1:0] haddr, // address
  input wire logic [1:0] htrans, // transfer
  input wire logic hwrite, // write
  input wire logic hready, // ready in
  input wire logic [31:0] hrdata, // read data
  input wire logic vbi_line, // vbi line
  input wire logic text_blank, // text blank
  input wire logic row_is_24, // row 24
  input wire acq_cfg_t acq_cfg, // acq controls
  input wire osd_cfg_t osd_cfg, // style controls
  input wire logic pkt24_to_page_mem, // pkt 24 place
  input wire logic row24_from_ext_mem, // row 24 source
  input wire logic row_visible, // row shown
  input wire logic decode_line_en, // decode line
  input wire logic [3:0] inventory_block, // inventory
  input wire logic vsync_late_half, // vsync half
  input wire logic overlay_blank // overlay
);
  logic wr_q;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'h0;
    end else begin
      wr_q <= hsel && hready && htrans[1] && hwrite;
    end
  end
  // inputs held still, so one register stage has caught up
  sequence s_quiet;
    $stable(acq_cfg) && $stable(vbi_line) && $stable(row_is_24);
  endsequence
  property p_store_place;
    $stable(acq_cfg) |-> pkt24_to_page_mem == acq_cfg.row24_store_place;
  endproperty
  a_store_place: assert property (p_store_place)
    else $error("packet 24 placement wrong");
  property p_show_source;
    $stable(acq_cfg) |-> row24_from_ext_mem == acq_cfg.row24_show_source;
  endproperty
  a_show_source: assert property (p_show_source)
    else $error("row 24 source wrong");
  property p_decode_line;
    s_quiet [*2] |-> decode_line_en == (acq_cfg.any_line_decode || vbi_line);
  endproperty
  a_decode_line: assert property (p_decode_line)
    else $error("line decode gate wrong");
  property p_row_visible;
    s_quiet [*2] ##0 acq_cfg.status_row_only |-> row_visible == row_is_24;
  endproperty
  a_row_visible: assert property (p_row_visible)
    else $error("status row gate wrong");
  property p_inventory;
    acq_cfg.inventory_capture_en [*2] |->
      inventory_block == 4'(INVENTORY_BLOCK);
  endproperty
  a_inventory: assert property (p_inventory)
    else $error("inventory block wrong");
  property p_overlay;
    overlay_blank |-> $past(text_blank);
  endproperty
  a_overlay: assert property (p_overlay)
    else $error("overlay blank without cause");
  property p_hold;
    !$stable({acq_cfg, osd_cfg, vsync_late_half}) |->
      $past(wr_q) || $past(wr_q, 2) || $past(wr_q, 3);
  endproperty
  a_hold: assert property (p_hold)
    else $error("control changed without write");
  property p_zero_read;
    hsel && hready && htrans[1] && !hwrite && haddr != REQ_STATUS_ADDR
      |=> hrdata == 32'h0;
  endproperty
  a_zero_read: assert property (p_zero_read)
    else $error("write-only read not zero");
endmodule : teletext_control_regs_chk

// file: tb/test_teletext_control_regs.sv
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin \
  failures++; $display("wrong value %s exp %h got %h", nm, ex, gt); end end
module test_teletext_control_regs
  import txt_ctrl_pkg::*;
;
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic hsel = 1'h0;
  logic [7:0] haddr = 8'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, q;
  logic hready, hreadyout, hresp, hsync_active, vsync_active;
  logic hsync_pin = 1'h0, vsync_pin = 1'h0, vbi_line = 1'h0;
  logic video_shown = 1'h0, text_blank = 1'h0, row_is_24 = 1'h0;
  logic [3:0] req_rd_page = 4'h0;
  logic [2:0] req_rd_column = 3'h0;
  logic [4:0] req_rd_value;
  acq_cfg_t acq_cfg;
  osd_cfg_t osd_cfg;
  logic pkt24_to_page_mem, row24_from_ext_mem, row_visible, decode_line_en;
  logic vsync_late_half, overlay_blank;
  logic [3:0] inventory_block;
  int failures = 0;
  int num_checks = 0;
  assign hready = hreadyout;
  teletext_control_regs dut (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
    .hsync_pin, .vsync_pin, .vbi_line, .video_shown, .text_blank, .row_is_24,
    .req_rd_page, .req_rd_column, .req_rd_value, .acq_cfg, .osd_cfg,
    .pkt24_to_page_mem, .row24_from_ext_mem, .row_visible, .decode_line_en,
    .inventory_block, .vsync_late_half, .hsync_active, .vsync_active,
    .overlay_blank);
  initial begin
    forever #2.5 hclk = ~hclk;
  end
  task automatic finish_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'h1 && n < 20);
    if (hreadyout !== 1'h1) begin
      failures++;
      finish_test();
    end
  endtask : wait_ready
  // one single transfer; only the low byte carries control data
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic [2:0] sz);
    hsel <= 1'h1;
    haddr <= a;
    hwrite <= w;
    hsize <= sz;
    htrans <= 2'h2;
    wait_ready();
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_ready();
    q = hrdata;
  endtask : bus
  task automatic t_acq();
    logic [7:0] tab [4] = '{8'ha5, 8'h5a, 8'hff, 8'h00};
    logic [7:0] d, s;
    `CHK("acq reset", 11'h0, acq_cfg)
    for (int i = 0; i < 4; i++) begin
      d = tab[i];
      s = tab[3-i];
      bus(1'h1, ACQ_DISPLAY_CTRL_ADDR, d, 3'h2);
      bus(1'h1, ACQ_SYNC_CTRL_ADDR, s, 3'h2);
      repeat (3) @(posedge hclk);
      `CHK("acq_cfg", {d[7:6], d[4:3], d[1:0], s[7:3]}, acq_cfg)
      `CHK("pkt24 place", d[7], pkt24_to_page_mem)
      `CHK("row24 source", d[6], row24_from_ext_mem)
      if (d[0]) `CHK("inventory", 4'h8, inventory_block)
    end
  endtask : t_acq
  task automatic t_gates();
    logic [5:0] b;
    for (int i = 0; i < 64; i++) begin
      b = 6'(i);
      bus(1'h1, ACQ_DISPLAY_CTRL_ADDR, {2'h0, b[1], 1'h0, b[2], b[0], 2'h0},
          3'h2);
      bus(1'h1, ACQ_SYNC_CTRL_ADDR, {4'h0, b[3], 3'h0}, 3'h2);
      video_shown <= b[4];
      row_is_24 <= b[4];
      vbi_line <= b[5];
      text_blank <= !b[5];
      repeat (3) @(posedge hclk);
      `CHK("overlay", !b[5] && !b[0] && !(b[1] && b[4]), overlay_blank)
      `CHK("row visible", !b[2] || b[4], row_visible)
      `CHK("decode line", b[3] || b[5], decode_line_en)
    end
  endtask : t_gates
  task automatic t_sync();
    logic [4:0] b;
    for (int i = 0; i < 32; i++) begin
      b = 5'(i);
      bus(1'h1, ACQ_SYNC_CTRL_ADDR, {5'h0, b[2:0]}, 3'h2);
      hsync_pin <= b[3];
      vsync_pin <= b[4];
      // pins pass a synchroniser first
      repeat (8) @(posedge hclk);
      `CHK("vsync half", b[2], vsync_late_half)
      `CHK("hsync", b[3] ^ b[1], hsync_active)
      `CHK("vsync", b[4] ^ b[0], vsync_active)
    end
  endtask : t_sync
  task automatic t_request();
    logic [7:0] sel [4] = '{8'h00, 8'h7f, 8'h2b, 8'h54};
    logic [4:0] val [4] = '{5'h1f, 5'h0a, 5'h15, 5'h01};
    for (int i = 0; i < 4; i++) begin
      bus(1'h1, PAGE_REQUEST_SELECT_ADDR, sel[i], 3'h2);
      bus(1'h1, PAGE_REQUEST_DATA_ADDR, {3'h0, val[i]}, 3'h2);
      bus(1'h0, REQ_STATUS_ADDR, 8'h0, 3'h2);
      `CHK("status", {val[i], sel[i]}, q[12:0])
    end
    for (int i = 0; i < 4; i++) begin
      req_rd_page <= sel[i][6:3];
      req_rd_column <= sel[i][2:0];
      repeat (2) @(posedge hclk);
      `CHK("request", val[i], req_rd_value)
    end
  endtask : t_request
  task automatic t_osd();
    `CHK("osd reset", 8'h0, osd_cfg)
    bus(1'h1, OSD_STYLE_CTRL_ADDR, 8'ha5, 3'h2);
    repeat (3) @(posedge hclk);
    `CHK("osd_cfg", 8'ha5, osd_cfg)
    bus(1'h1, OSD_STYLE_CTRL_ADDR, 8'h5a, 3'h2);
    // byte write and stray address must both leave the style alone
    bus(1'h1, OSD_STYLE_CTRL_ADDR, 8'hff, 3'h0);
    bus(1'h1, 8'h20, 8'hff, 3'h2);
    repeat (3) @(posedge hclk);
    `CHK("osd_cfg", 8'h5a, osd_cfg)
    bus(1'h0, 8'h20, 8'h0, 3'h2);
    `CHK("unmapped", 32'h0, q)
    bus(1'h0, OSD_STYLE_CTRL_ADDR, 8'h0, 3'h2);
    `CHK("osd read", 32'h0, q)
    `CHK("hresp", 1'h0, hresp)
    `CHK("hreadyout", 1'h1, hreadyout)
    hresetn <= 1'h0;
    repeat (2) @(posedge hclk);
    `CHK("osd reset", 8'h0, osd_cfg)
    hresetn <= 1'h1;
    @(posedge hclk);
  endtask : t_osd
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    t_acq();
    t_gates();
    t_sync();
    t_request();
    t_osd();
    finish_test();
  end
endmodule : test_teletext_control_regs
bind teletext_control_regs teletext_control_regs_chk #(
  .INVENTORY_BLOCK(INVENTORY_BLOCK)
) chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata,
  .vbi_line, .text_blank, .row_is_24, .acq_cfg, .osd_cfg, .pkt24_to_page_mem,
  .row24_from_ext_mem, .row_visible, .decode_line_en, .inventory_block,
  .vsync_late_half, .overlay_blank);
